// >>> clk_switch_pkg.sv
// Purpose: shared constants and types for the cpu clock switchover block
// Assumes: one apb register word, clock sources arrive as pclk-synchronous ticks
// Notes:   offsets, field positions and reset values are defined here; the assertions and the bench repeat some as literals
package clk_switch_pkg;

    // register map (byte addresses)
    localparam logic [11:0] SYSCLK_SEL_OFFSET = 12'h000;

    // field positions inside system_clock_select
    localparam int DIV_LSB        = 0;   // main_div_sel_bit0
    localparam int DIV_MSB        = 2;   // main_div_sel_bit2
    localparam int MAIN_SRC_BIT   = 4;   // main_src_sel
    localparam int MAIN_STAT_BIT  = 5;   // main_src_status, read only
    localparam int CPU_SRC_BIT    = 6;   // cpu_src_sel
    localparam int CPU_STAT_BIT   = 7;   // cpu_src_status, read only

    // reset values of the writable fields
    localparam logic [2:0] DIV_RESET      = 3'h0;
    localparam logic       MAIN_SRC_RESET = 1'b0;  // internal oscillator
    localparam logic       CPU_SRC_RESET  = 1'b0;  // main system clock

    // largest legal division exponent; larger writes leave the field unchanged
    localparam logic [2:0] DIV_MAX        = 3'h4;

    // divide-by-two applied to the subsystem clock on the cpu path
    localparam logic [2:0] SUB_HALF_DIV   = 3'h1;

    // divider counter width, enough for 2**DIV_MAX source ticks
    localparam int DIV_CNT_W = 5;

    // pclk period in nanoseconds, 20 MHz
    localparam int PCLK_PERIOD_NS = 50;

    // switchover sequencer states
    typedef enum logic [1:0] {
        SW_IDLE,
        SW_WAIT_OLD,
        SW_WAIT_NEW
    } sw_state_type;

    // kind of switchover in progress
    typedef enum logic [1:0] {
        KIND_NONE,
        KIND_DIV,
        KIND_MAIN_SRC,
        KIND_CPU_SRC
    } switch_kind_type;

endpackage

// >>> tick_divider.sv
// Purpose: divide a stream of source ticks by 2**div
// Assumes: src_tick is a one-cycle pulse synchronous to pclk
// Notes:   clear restarts the count so the first output tick is a full period away
`timescale 1ns/1ps
module tick_divider #(
    parameter int CNT_W = clk_switch_pkg::DIV_CNT_W
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       src_tick,
    input  wire logic [2:0] div,
    input  wire logic       clear,
    output logic            out_tick
);

    // all state of the divider
    typedef struct packed {
        logic [CNT_W-1:0] cnt;   // source ticks seen in this period
    } div_state_type;

    div_state_type s_q;   // registered state
    div_state_type s_d;   // next state
    logic [CNT_W-1:0] last;  // count value that ends a period

    // terminal count and next count
    always_comb begin
        s_d      = s_q;
        last     = CNT_W'((32'h1 << div) - 32'h1);
        out_tick = src_tick && (s_q.cnt >= last) && !clear;
        if (clear) begin
            // restart so no short first pulse
            s_d.cnt = '0;
        end else if (src_tick) begin
            s_d.cnt = (s_q.cnt >= last) ? '0 : CNT_W'(s_q.cnt + 1'b1);
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule // tick_divider

// >>> cpu_clock_switchover.sv
// Purpose: cpu clock selection and deferred, glitch-free switchover
// Assumes: ih_tick, mx_tick, sub_tick are pclk-synchronous source clock ticks
// Notes:   the cpu and peripheral clocks leave as one-cycle enable ticks
//
// Notes on behaviour
// [RQ1] divider field bits 0-2, sources bits 4, 6
// [RQ2] keep old clock running before completing switch
// [RQ3] bit 7 reports cpu clock source
// [RQ4] bit 5 reports main clock source
// [RQ5] peripheral clock follows cpu clock source
// [RQ6] divider, main source, cpu source switches distinct
// [RQ7] divider change ends within old plus new period
// [RQ8] source change ends within old plus new period
// [RQ9] no short pulses; status updates on handover
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
module cpu_clock_switchover (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        ih_tick,
    input  wire logic        mx_tick,
    input  wire logic        sub_tick,
    output logic             cpu_clk_tick,
    output logic             periph_clk_tick,
    output logic             switch_busy,
    output logic [1:0]       switch_kind,
    output logic             cpu_src_status,
    output logic             main_src_status
);

    // all state of the block
    typedef struct packed {
        clk_switch_pkg::sw_state_type    st;        // sequencer state
        clk_switch_pkg::switch_kind_type kind;      // switch in progress
        logic [2:0]                      div_req;   // software division request
        logic                            msrc_req;  // software main source request
        logic                            csrc_req;  // software cpu source request
        logic [2:0]                      div_act;   // division in use
        logic                            msrc_act;  // main source in use
        logic                            csrc_act;  // cpu source in use
        logic [2:0]                      div_tgt;   // division being switched to
        logic                            msrc_tgt;  // main source being switched to
        logic                            csrc_tgt;  // cpu source being switched to
        logic                            settle;    // first wait-new cycle, new ticks held off
        logic [31:0]                     rdata;     // read data for the access phase
        logic                            err;       // error answer for the access phase
    } state_type;

    state_type s_q;   // registered state
    state_type s_d;   // next state

    logic       setup_ph;     // apb setup cycle
    logic       access_ph;    // apb access cycle, write commits here
    logic       hit;          // address decodes to the register
    logic       old_src;      // source tick feeding the active divider
    logic       new_src;      // source tick feeding the target divider
    logic       old_main;     // active main clock tick
    logic       new_main;     // target main clock tick
    logic       sub_half;     // subsystem clock divided by two
    logic       old_cpu;      // cpu tick from the active selection
    logic       new_cpu;      // cpu tick from the target selection
    logic       new_clear;    // hold target divider cleared throughout wait-old
    logic       old_clear;    // realign active divider with the new phase
    logic       cpu_tick;     // gated cpu tick
    logic [7:0] reg_view;     // register as software sees it

    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;
    assign hit       = (paddr == clk_switch_pkg::SYSCLK_SEL_OFFSET);
    assign pready    = 1'b1;   // zero wait states

    // source selection for the two main-clock dividers
    assign old_src = s_q.msrc_act ? mx_tick : ih_tick;
    assign new_src = s_q.msrc_tgt ? mx_tick : ih_tick;
    assign new_clear = (s_q.st == clk_switch_pkg::SW_WAIT_OLD);

    // at the commit tick the active divider restarts with the target one;
    // left alone, its stale count from the old setting would cut the
    // first period after the handover short
    assign old_clear = (s_q.st == clk_switch_pkg::SW_WAIT_NEW) && !s_q.settle
                       && new_cpu;                                            // [RQ9]

    // divider running on the clock now in use
    tick_divider #(.CNT_W(clk_switch_pkg::DIV_CNT_W)) u_old_div (
        .pclk     (pclk),
        .presetn  (presetn),
        .src_tick (old_src),
        .div      (s_q.div_act),
        .clear    (old_clear),
        .out_tick (old_main)
    );

    // divider running on the clock being switched to, restarted so its
    // first pulse is whole rather than a fragment
    tick_divider #(.CNT_W(clk_switch_pkg::DIV_CNT_W)) u_new_div (
        .pclk     (pclk),
        .presetn  (presetn),
        .src_tick (new_src),
        .div      (s_q.div_tgt),
        .clear    (new_clear),
        .out_tick (new_main)
    );

    // half-rate subsystem clock for the cpu path
    tick_divider #(.CNT_W(clk_switch_pkg::DIV_CNT_W)) u_sub_div (
        .pclk     (pclk),
        .presetn  (presetn),
        .src_tick (sub_tick),
        .div      (clk_switch_pkg::SUB_HALF_DIV),
        .clear    (1'b0),
        .out_tick (sub_half)
    );

    assign old_cpu = s_q.csrc_act ? sub_half : old_main;
    assign new_cpu = s_q.csrc_tgt ? sub_half : new_main;

    // software view: requests in writable bits, active sources in status bits
    always_comb begin
        reg_view = 8'h00;
        reg_view[clk_switch_pkg::DIV_MSB:clk_switch_pkg::DIV_LSB] = s_q.div_req;  // [RQ1]
        reg_view[clk_switch_pkg::MAIN_SRC_BIT]  = s_q.msrc_req;                   // [RQ1]
        reg_view[clk_switch_pkg::CPU_SRC_BIT]   = s_q.csrc_req;                   // [RQ1]
        reg_view[clk_switch_pkg::CPU_STAT_BIT]  = s_q.csrc_act;                   // [RQ3]
        reg_view[clk_switch_pkg::MAIN_STAT_BIT] = s_q.msrc_act;                   // [RQ4]
    end

    // bus, sequencer and tick gating
    always_comb begin
        s_d      = s_q;
        cpu_tick = 1'b0;

        // read data captured in setup so the answer comes from a flop
        if (setup_ph) begin
            s_d.rdata = hit ? {24'h000000, reg_view} : 32'h00000000;
            s_d.err   = !hit;
        end

        // writes only touch the request fields; status bits are read only
        if (access_ph && pwrite && hit) begin
            if (pwdata[clk_switch_pkg::DIV_MSB:clk_switch_pkg::DIV_LSB]
                    <= clk_switch_pkg::DIV_MAX) begin
                s_d.div_req = pwdata[clk_switch_pkg::DIV_MSB:clk_switch_pkg::DIV_LSB]; // [RQ1]
            end
            s_d.msrc_req = pwdata[clk_switch_pkg::MAIN_SRC_BIT];                       // [RQ1]
            s_d.csrc_req = pwdata[clk_switch_pkg::CPU_SRC_BIT];                        // [RQ1]
        end

        unique case (s_q.st)
            clk_switch_pkg::SW_IDLE: begin
                cpu_tick = old_cpu;
                // a new request is picked up on the cycle after the write
                if (s_q.csrc_req != s_q.csrc_act || s_q.msrc_req != s_q.msrc_act
                        || s_q.div_req != s_q.div_act) begin
                    s_d.div_tgt  = s_q.div_req;
                    s_d.msrc_tgt = s_q.msrc_req;
                    s_d.csrc_tgt = s_q.csrc_req;
                    s_d.st       = clk_switch_pkg::SW_WAIT_OLD;
                    // cpu source outranks main source outranks divider
                    if (s_q.csrc_req != s_q.csrc_act) begin
                        s_d.kind = clk_switch_pkg::KIND_CPU_SRC;   // [RQ6]
                    end else if (s_q.msrc_req != s_q.msrc_act) begin
                        s_d.kind = clk_switch_pkg::KIND_MAIN_SRC;  // [RQ6]
                    end else begin
                        s_d.kind = clk_switch_pkg::KIND_DIV;       // [RQ6]
                    end
                end
            end
            clk_switch_pkg::SW_WAIT_OLD: begin
                // the old clock keeps running until its current period ends
                cpu_tick = old_cpu;                                  // [RQ2]
                if (old_cpu) begin
                    s_d.st     = clk_switch_pkg::SW_WAIT_NEW;        // [RQ7] [RQ8]
                    s_d.settle = 1'b1;                               // [RQ9]
                end
            end
            clk_switch_pkg::SW_WAIT_NEW: begin
                if (s_q.settle) begin
                    // a new tick right after the old one would merge the two
                    // into a clock that never goes low; costs at most one new period
                    s_d.settle = 1'b0;                               // [RQ9]
                end else begin
                    // silent until the new clock ticks: a whole period of the restarted main divider, or the next free-running sub_half tick
                    cpu_tick = new_cpu;                              // [RQ9]
                    if (new_cpu) begin
                        s_d.div_act  = s_q.div_tgt;                  // [RQ7]
                        s_d.msrc_act = s_q.msrc_tgt;                 // [RQ8] [RQ9]
                        s_d.csrc_act = s_q.csrc_tgt;                 // [RQ9]
                        s_d.kind     = clk_switch_pkg::KIND_NONE;
                        s_d.st       = clk_switch_pkg::SW_IDLE;
                    end
                end
            end
            default: begin
                // unused state code: recover to idle
                s_d.st = clk_switch_pkg::SW_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q          <= '0;
            s_q.st       <= clk_switch_pkg::SW_IDLE;
            s_q.kind     <= clk_switch_pkg::KIND_NONE;
            s_q.div_req  <= clk_switch_pkg::DIV_RESET;
            s_q.div_act  <= clk_switch_pkg::DIV_RESET;
            s_q.div_tgt  <= clk_switch_pkg::DIV_RESET;
            s_q.msrc_req <= clk_switch_pkg::MAIN_SRC_RESET;
            s_q.msrc_act <= clk_switch_pkg::MAIN_SRC_RESET;
            s_q.msrc_tgt <= clk_switch_pkg::MAIN_SRC_RESET;
            s_q.csrc_req <= clk_switch_pkg::CPU_SRC_RESET;
            s_q.csrc_act <= clk_switch_pkg::CPU_SRC_RESET;
            s_q.csrc_tgt <= clk_switch_pkg::CPU_SRC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs; the peripheral clock is the cpu clock by construction
    assign cpu_clk_tick    = cpu_tick;
    assign periph_clk_tick = cpu_tick;                       // [RQ5]
    assign prdata          = s_q.rdata;
    assign pslverr         = s_q.err && access_ph;
    assign switch_busy     = (s_q.st != clk_switch_pkg::SW_IDLE);
    assign switch_kind     = s_q.kind;
    assign cpu_src_status  = s_q.csrc_act;                   // [RQ3]
    assign main_src_status = s_q.msrc_act;                   // [RQ4]

    // write of the field shows up as the request one cycle later
    write_lands_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ1]
        access_ph && pwrite && hit
        |=> s_q.csrc_req == $past(pwdata[clk_switch_pkg::CPU_SRC_BIT])
        && s_q.msrc_req == $past(pwdata[clk_switch_pkg::MAIN_SRC_BIT])
        && ($past(pwdata[2:0]) > clk_switch_pkg::DIV_MAX
            || s_q.div_req == $past(pwdata[2:0])))
        else $error("register write did not update request fields");

    // an out-of-range divider write leaves the divider request alone
    div_refused_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ1]
        access_ph && pwrite && hit && pwdata[2:0] > clk_switch_pkg::DIV_MAX
        |=> $stable(s_q.div_req))
        else $error("illegal divider value was accepted");

    // status does not move while the old clock still runs
    sequence old_phase_s;
        s_q.st == clk_switch_pkg::SW_WAIT_OLD && !old_cpu;
    endsequence
    old_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ2]
        old_phase_s |=> $stable(cpu_src_status) && $stable(main_src_status)
        && s_q.st == clk_switch_pkg::SW_WAIT_OLD)
        else $error("switch completed before old clock period ended");

    // status bits track the active selection visible on a read
    cpu_status_read_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ3]
        setup_ph && hit |=> prdata[7] == $past(cpu_src_status))
        else $error("cpu source status bit wrong on read");

    main_status_read_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ4]
        setup_ph && hit |=> prdata[5] == $past(main_src_status))
        else $error("main source status bit wrong on read");

    periph_follows_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ5]
        periph_clk_tick == cpu_clk_tick)
        else $error("peripheral clock diverged from cpu clock");

    // a cpu source mismatch seen in idle is classed as the cpu source kind
    kind_cpu_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ6]
        s_q.st == clk_switch_pkg::SW_IDLE && s_q.csrc_req != s_q.csrc_act
        |=> switch_kind == 2'(clk_switch_pkg::KIND_CPU_SRC))
        else $error("switch kind misclassified");

    // a main source change with the cpu source unchanged is its own kind
    kind_main_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ6]
        s_q.st == clk_switch_pkg::SW_IDLE && s_q.csrc_req == s_q.csrc_act
        && s_q.msrc_req != s_q.msrc_act
        |=> switch_kind == 2'(clk_switch_pkg::KIND_MAIN_SRC))
        else $error("main source switch misclassified");

    // the switch ends with a new-clock tick and updates status on it
    sequence new_edge_s;
        s_q.st == clk_switch_pkg::SW_WAIT_NEW && cpu_clk_tick;
    endsequence
    handover_commit_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ8]
        new_edge_s |=> !switch_busy && cpu_src_status == $past(s_q.csrc_tgt)
        && main_src_status == $past(s_q.msrc_tgt))
        else $error("handover did not commit the target selection");

    // the cycle after the last old tick stays silent, whatever the new clock does
    gap_silent_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ9]
        s_q.st == clk_switch_pkg::SW_WAIT_OLD && old_cpu |=> !cpu_clk_tick)
        else $error("clock pulse during handover gap");

    // once the old period ends the sequencer moves to wait for the new clock
    old_to_new_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RQ7]
        s_q.st == clk_switch_pkg::SW_WAIT_OLD && old_cpu
        |=> s_q.st == clk_switch_pkg::SW_WAIT_NEW)
        else $error("switch did not proceed after old period ended");

endmodule // cpu_clock_switchover

// >>> testbench.sv
// Purpose: self-checking bench for the cpu clock switchover block
// Assumes: source ticks come every 2 (ih), 3 (mx) and 5 (sub) pclk cycles
// Notes:   expected tick periods are worked out here from the field values
`timescale 1ns/1ps
module testbench;
    logic        pclk;            // 20 MHz bus clock
    logic        presetn;         // async reset, active low
    logic        psel;            // apb select
    logic        penable;         // apb access phase
    logic        pwrite;          // apb direction
    logic [11:0] paddr;           // apb byte address
    logic [31:0] pwdata;          // apb write data
    logic [31:0] prdata;          // apb read data
    logic        pready;          // apb ready
    logic        pslverr;         // apb error
    logic        ih_tick;         // internal oscillator tick
    logic        mx_tick;         // high-speed system clock tick
    logic        sub_tick;        // subsystem clock tick
    logic        cpu_clk_tick;    // cpu clock enable
    logic        periph_clk_tick; // peripheral clock enable
    logic        switch_busy;     // switchover in progress
    logic [1:0]  switch_kind;     // kind of switchover
    logic        cpu_src_status;  // active cpu source
    logic        main_src_status; // active main source
    int          n_mismatch;      // failed comparisons
    int          comparisons;     // all comparisons
    int          cyc;             // cycles since start, also the hang limit
    int          last_tick;       // cycle of the latest cpu tick
    int          gap;             // spacing of the two latest cpu ticks
    int          busy_ticks;      // cpu ticks seen while busy
    int          min_gap;         // shortest legal tick spacing just now
    logic [7:0]  cur;             // value the register should hold
    logic [31:0] rd;              // read data of the last transfer
    logic        err;             // error of the last transfer

    cpu_clock_switchover cpu_clock_switchover_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .ih_tick(ih_tick), .mx_tick(mx_tick), .sub_tick(sub_tick),
        .cpu_clk_tick(cpu_clk_tick), .periph_clk_tick(periph_clk_tick),
        .switch_busy(switch_busy), .switch_kind(switch_kind),
        .cpu_src_status(cpu_src_status), .main_src_status(main_src_status)
    );

    // free-running clock, 50 ns period
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // source ticks with fixed spacing, plus the hang limit
    always @(posedge pclk) begin
        cyc++;
        ih_tick  <= (cyc % 2) == 0;
        mx_tick  <= (cyc % 3) == 0;
        sub_tick <= (cyc % 5) == 0;
        if (cyc >= 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // tick watcher on the falling edge, where combinational ticks are settled
    always @(negedge pclk) begin
        if (presetn === 1'b1) begin
            check(periph_clk_tick, cpu_clk_tick, "periph tick differs");
            if (cpu_clk_tick === 1'b1) begin
                gap = cyc - last_tick;
                last_tick = cyc;
                if (switch_busy === 1'b1) busy_ticks++;
                check(gap >= min_gap, 1'b1, "short clock pulse");
            end
        end
    end

    // single compare, four-state
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // expected cpu tick period for a register value; sub path is halved
    function automatic int per(input logic [7:0] v);
        return v[6] ? 10 : ((v[4] ? 3 : 2) << v[2:0]);
    endfunction

    // one apb transfer, held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        check(pready, 1'b1, "no ready");
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // wait for k cpu ticks, bounded, then let the watcher settle
    task automatic wait_ticks(input int k);
        int n;
        int t;
        n = 0;
        t = 0;
        while (t < k && n < 300) begin
            @(negedge pclk);
            n++;
            if (cpu_clk_tick === 1'b1) t++;
        end
        @(posedge pclk);
    endtask

    // write a new selection and follow the whole switchover
    task automatic switch_to(input logic [7:0] v, input logic [1:0] kind);
        int   n;
        int   oldp;
        int   newp;
        logic cs;
        logic ms;
        oldp = per(cur);
        newp = per(v);
        cs = cpu_src_status;
        ms = main_src_status;
        min_gap = oldp;
        busy_ticks = 0;
        apb(1'b1, 12'h000, {24'h0, v});
        n = 0;
        while (switch_busy !== 1'b1 && n < 4) begin
            @(negedge pclk);
            n++;
        end
        check(switch_busy, 1'b1, "switch not started");
        check(switch_kind, kind, "switch kind");
        // the new clock's first edge may come early in its period, never merged
        min_gap = 2;
        n = 0;
        // status must hold the old sources until handover
        while (switch_busy === 1'b1 && n < 400) begin
            check({cs, ms}, {cpu_src_status, main_src_status}, "early status");
            @(negedge pclk);
            n++;
        end
        check(n <= oldp + newp + 2, 1'b1, "switch too slow");
        check(busy_ticks, 2, "old clock stopped early");
        check({cpu_src_status, main_src_status}, {v[6], v[4]}, "status");
        cur = v;
        min_gap = newp;
        wait_ticks(3);
        check(gap, newp, "new tick period");
    endtask

    // verdict and end of run
    task automatic tally_and_finish();
        if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // main sequence
    initial begin
        int n;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ih_tick = 1'b0;
        mx_tick = 1'b0;
        sub_tick = 1'b0;
        {n_mismatch, comparisons, cyc, last_tick, gap, busy_ticks} = '0;
        min_gap = 2;
        cur = 8'h00;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0, "reset value");
        check(err, 1'b0, "mapped error");
        check({cpu_src_status, main_src_status}, 2'h0, "reset status");
        wait_ticks(3);
        check(gap, 2, "reset period");
        switch_to(8'h01, 2'h1);
        switch_to(8'h04, 2'h1);
        // illegal divider and read-only bits leave the register as it is
        apb(1'b1, 12'h000, 32'h07);
        apb(1'b1, 12'h000, 32'ha4);
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h04, "ignored bits");
        check(switch_busy, 1'b0, "needless switch");
        switch_to(8'h00, 2'h1);
        switch_to(8'h10, 2'h2);
        switch_to(8'h50, 2'h3);
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'hf0, "status readback");
        switch_to(8'h00, 2'h3);
        // second write lands while the first switch runs
        min_gap = 2;
        apb(1'b1, 12'h000, 32'h01);
        apb(1'b1, 12'h000, 32'h02);
        n = 0;
        while (n < 60) begin
            @(negedge pclk);
            n = (switch_busy === 1'b1) ? 0 : n + 1;
        end
        cur = 8'h02;
        min_gap = 8;
        wait_ticks(3);
        check(gap, 8, "queued switch period");
        // unmapped place: write dropped, read zero with error
        apb(1'b1, 12'h004, 32'h03);
        check(err, 1'b1, "unmapped write error");
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h0, "unmapped read");
        check(err, 1'b1, "unmapped read error");
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h02, "final value");
        tally_and_finish();
    end
endmodule // testbench
